/* rtl/dpwr_host.v */
// Host controller that drives one asynchronous dual-port RAM port.
`timescale 1ns/1ps
`default_nettype none
`include "dpwr_consts.vh"
module dpwr_host #(
	parameter ADDR_W = 13,
	parameter DATA_W = 16
) (
	input wire clk,
	input wire resetn,
	input wire reqValid,
	input wire [1:0] reqCmd,
	input wire [ADDR_W-1:0] reqAddr,
	input wire [DATA_W-1:0] reqData,
	input wire [1:0] reqByteEn,
	input wire reqOutEnable,
	output reg reqReady,
	output reg rspValid,
	output reg [DATA_W-1:0] rspData,
	output reg [ADDR_W-1:0] addr,
	output reg chipSelectN,
	output reg upper_byte_select_n,
	output reg lower_byte_select_n,
	output reg flag_select_n,
	output reg readWriteN,
	output reg outputEnableN,
	input wire [DATA_W-1:0] dataIn,
	output reg [DATA_W-1:0] dataOut,
	output reg dataOeN
);
	////////////////////////////////////////////////////////////////////////////
	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_SETUP = 6'h02;
	localparam [5:0] ST_PULSE = 6'h04;
	localparam [5:0] ST_HOLD = 6'h08;
	localparam [5:0] ST_READ = 6'h10;
	localparam [5:0] ST_GAP = 6'h20;
	localparam integer CYC_EW_N = `DPWR_CYC_EW;
	localparam integer CYC_WP_N = `DPWR_CYC_WP;
	localparam integer CYC_WPOE_N = `DPWR_CYC_WPOE;
	localparam integer CYC_DH_N = `DPWR_CYC_DH;
	localparam integer CYC_SWRD_N = `DPWR_CYC_SWRD;
	localparam [7:0] CYC_EW = CYC_EW_N[7:0];
	localparam [7:0] CYC_WP = CYC_WP_N[7:0];
	localparam [7:0] CYC_WPOE = CYC_WPOE_N[7:0];
	localparam [7:0] CYC_DH = CYC_DH_N[7:0];
	localparam [7:0] CYC_SWRD = CYC_SWRD_N[7:0];
	localparam [7:0] CYC_RD = 8'h02;

	wire [DATA_W-1:0] dataSync;
	reg [5:0] state_q;
	reg [5:0] state_d;
	reg [7:0] count_q;
	reg [7:0] count_d;
	reg [1:0] cmd_q;
	reg flagWritten_q;
	reg [7:0] gapCount_q;
	reg [1:0] byteEn_q;
	wire isFlag;
	wire [7:0] pulseLen;

	dpwr_sync2 #(.WIDTH(DATA_W)) u_sync (
		.clk(clk),
		.resetn(resetn),
		.async(dataIn),
		.synced(dataSync)
	);

	assign isFlag = cmd_q[1];
	// The pulse covers the select-to-end time as well, since selects fall with the strobe.
	assign pulseLen = (outputEnableN == 1'b0) ?
		((CYC_WPOE > CYC_WP) ? CYC_WPOE : CYC_WP) : CYC_WP;
	////////////////////////////////////////////////////////////////////////////
	always @*
	begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			ST_IDLE:
			begin
				if (reqValid && reqReady)
				begin
					state_d = ST_SETUP;
					count_d = 8'h00;
				end
			end
			ST_SETUP:
			begin
				if (cmd_q[0])
					state_d = ST_READ;
				else
					state_d = ST_PULSE;
				count_d = 8'h01;
			end
			ST_PULSE:
			begin
				count_d = count_q + 8'h01;
				// The first strobe cycle lets the device turn off, then data stands for the pulse.
				if (count_q > ((pulseLen > CYC_EW) ? pulseLen : CYC_EW))
				begin
					state_d = ST_HOLD;
					count_d = 8'h01;
				end
			end
			ST_HOLD:
			begin
				count_d = count_q + 8'h01;
				if (count_q >= CYC_DH)
					state_d = ST_GAP;
			end
			ST_READ:
			begin
				count_d = count_q + 8'h01;
				if (count_q >= CYC_RD + 8'h02)
					state_d = ST_GAP;
			end
			ST_GAP:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= ST_IDLE;
			count_q <= 8'h00;
			cmd_q <= 2'h0;
			flagWritten_q <= 1'b0;
			gapCount_q <= 8'h00;
			reqReady <= 1'b0;
			rspValid <= 1'b0;
			rspData <= {DATA_W{1'b0}};
			addr <= {ADDR_W{1'b0}};
			chipSelectN <= 1'b1;
			upper_byte_select_n <= 1'b1;
			lower_byte_select_n <= 1'b1;
			flag_select_n <= 1'b1;
			readWriteN <= 1'b1;
			outputEnableN <= 1'b1;
			dataOut <= {DATA_W{1'b0}};
			dataOeN <= 1'b1;
		end
		else
		begin
			state_q <= state_d;
			count_q <= count_d;
			rspValid <= 1'b0;
			if (gapCount_q != 8'h00)
				gapCount_q <= gapCount_q - 8'h01;
			// A flag read waits until the write-to-read time has passed.
			reqReady <= (state_d == ST_IDLE) && !(flagWritten_q && gapCount_q > 8'h01
				&& reqCmd == `DPWR_CMD_FLAG_READ);
			case (state_q)
				ST_IDLE:
				begin
					if (reqValid && reqReady)
					begin
						cmd_q <= reqCmd;
						addr <= reqAddr;
						dataOut <= reqData;
						outputEnableN <= reqCmd[0] ? 1'b0 : !reqOutEnable;
						if (reqCmd == `DPWR_CMD_FLAG_READ)
							flagWritten_q <= 1'b0;
					end
				end
				ST_SETUP:
				begin
					// On a write, selects and strobe fall together so the device keeps its outputs off.
					readWriteN <= cmd_q[0];
					flag_select_n <= !isFlag;
					chipSelectN <= isFlag;
					upper_byte_select_n <= isFlag ? 1'b1 : !byteEn_q[1];
					lower_byte_select_n <= isFlag ? 1'b1 : !byteEn_q[0];
				end
				ST_PULSE:
				begin
					// Data goes out one cycle after the strobe so the device has turned off.
					dataOeN <= 1'b0;
					if (state_d == ST_HOLD)
					begin
						readWriteN <= 1'b1;
						chipSelectN <= 1'b1;
						upper_byte_select_n <= 1'b1;
						lower_byte_select_n <= 1'b1;
						flag_select_n <= 1'b1;
					end
				end
				ST_HOLD:
				begin
					if (state_d == ST_GAP)
					begin
						dataOeN <= 1'b1;
						outputEnableN <= 1'b1;
						if (isFlag)
						begin
							flagWritten_q <= 1'b1;
							gapCount_q <= CYC_SWRD + 8'h01;
						end
					end
				end
				ST_READ:
				begin
					if (state_d == ST_GAP)
					begin
						// A flag read reports bit 0, which all data pins carry.
						rspData <= isFlag ? {DATA_W{dataSync[0]}} : dataSync;
						rspValid <= 1'b1;
						chipSelectN <= 1'b1;
						upper_byte_select_n <= 1'b1;
						lower_byte_select_n <= 1'b1;
						flag_select_n <= 1'b1;
						outputEnableN <= 1'b1;
					end
				end
				default:
				begin
				end
			endcase
		end
	end
	////////////////////////////////////////////////////////////////////////////
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			byteEn_q <= 2'h0;
		else if (state_q == ST_IDLE && reqValid && reqReady)
			byteEn_q <= (reqByteEn == 2'h0) ? 2'h3 : reqByteEn;
	end
endmodule // dpwr_host
`default_nettype wire

/* shared/dpwr_consts.vh */
// Timing constants and command codes for the dual-port RAM write host.
`ifndef DPWR_CONSTS_VH
`define DPWR_CONSTS_VH
`define DPWR_CLK_PERIOD_NS 100
`define DPWR_T_EW_NS 70
`define DPWR_T_WP_NS 50
`define DPWR_T_WZ_NS 30
`define DPWR_T_DW_NS 40
`define DPWR_T_DH_NS 0
`define DPWR_T_SWRD_NS 5
`define DPWR_T_AS_NS 0
`define DPWR_CYC_UP(t) ((((t) + `DPWR_CLK_PERIOD_NS - 1) / `DPWR_CLK_PERIOD_NS) < 1 ? 1 : (((t) + `DPWR_CLK_PERIOD_NS - 1) / `DPWR_CLK_PERIOD_NS))
`define DPWR_CYC_EW `DPWR_CYC_UP(`DPWR_T_EW_NS)
`define DPWR_CYC_WPOE `DPWR_CYC_UP(`DPWR_T_WZ_NS + `DPWR_T_DW_NS)
`define DPWR_CYC_WP `DPWR_CYC_UP(`DPWR_T_WP_NS)
`define DPWR_CYC_DH `DPWR_CYC_UP(`DPWR_T_DH_NS)
`define DPWR_CYC_SWRD `DPWR_CYC_UP(`DPWR_T_SWRD_NS)
`define DPWR_CMD_WRITE 2'h0
`define DPWR_CMD_READ 2'h1
`define DPWR_CMD_FLAG_WRITE 2'h2
`define DPWR_CMD_FLAG_READ 2'h3
`endif

/* rtl/dpwr_sync2.v */
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module dpwr_sync2 #(
	parameter WIDTH = 16
) (
	input wire clk,
	input wire resetn,
	input wire [WIDTH-1:0] async,
	output reg [WIDTH-1:0] synced
);
	reg [WIDTH-1:0] stage_q;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			stage_q <= {WIDTH{1'b0}};
			synced <= {WIDTH{1'b0}};
		end
		else
		begin
			stage_q <= async;
			synced <= stage_q;
		end
	end
endmodule // dpwr_sync2
`default_nettype wire

/* test/dpwr_host_sva.sv */
// Checker for the host's pin sequencing.
`timescale 1ns/1ps
`default_nettype none
module dpwr_host_sva (
	input wire logic clk,
	input wire logic resetn,
	input wire logic [12:0] addr,
	input wire logic chipSelectN,
	input wire logic upper_byte_select_n,
	input wire logic lower_byte_select_n,
	input wire logic flag_select_n,
	input wire logic readWriteN,
	input wire logic dataOeN
);
	wire bothOff = upper_byte_select_n && lower_byte_select_n;
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	arr_sel_a: assert property (!chipSelectN |-> flag_select_n && !bothOff)
		else $error("array mix");
	flg_sel_a: assert property (!flag_select_n |-> chipSelectN || bothOff)
		else $error("flag mix");
	sel_held_a: assert property (!readWriteN |-> !chipSelectN || !flag_select_n)
		else $error("select drop");
	addr_move_a: assert property (!$stable(addr) |-> readWriteN && $past(readWriteN))
		else $error("address move");
	drive_late_a: assert property ($fell(dataOeN) |-> !$past(readWriteN))
		else $error("data early");
	data_setup_a: assert property ($rose(readWriteN) |-> !$past(dataOeN))
		else $error("no setup");
	data_hold_a: assert property ($rose(readWriteN) |-> !dataOeN)
		else $error("no hold");
	flag_gap_a: assert property ($rose(flag_select_n) |=> flag_select_n)
		else $error("flag gap");
endmodule // dpwr_host_sva
bind dpwr_host dpwr_host_sva dpwr_host_sva_inst (
	.clk(clk),
	.resetn(resetn),
	.addr(addr),
	.chipSelectN(chipSelectN),
	.upper_byte_select_n(upper_byte_select_n),
	.lower_byte_select_n(lower_byte_select_n),
	.flag_select_n(flag_select_n),
	.readWriteN(readWriteN),
	.dataOeN(dataOeN)
);
`default_nettype wire

/* test/dpwr_ram_model.sv */
// Model of one RAM port: array, flag bits and data pins.
`timescale 1ns/1ps
`default_nettype none
module dpwr_ram_model (
	input wire logic clk,
	input wire logic [12:0] addr,
	input wire logic chipSelectN,
	input wire logic upper_byte_select_n,
	input wire logic lower_byte_select_n,
	input wire logic flag_select_n,
	input wire logic readWriteN,
	input wire logic outputEnableN,
	input wire logic [15:0] dataOut,
	input wire logic dataOeN,
	output logic [15:0] dataIn
);
	logic [15:0] mem [0:8191];
	logic [7:0] flag = 8'hff;
	logic [15:0] lastQ = 16'h0;
	wire byteOn = !(upper_byte_select_n && lower_byte_select_n);
	wire arrSel = !chipSelectN && byteOn && flag_select_n;
	wire flgSel = !flag_select_n && (chipSelectN || !byteOn);
	wire devOn = readWriteN && !outputEnableN && (arrSel || flgSel);
	wire [15:0] devQ = arrSel ? mem[addr] : {16{flag[addr[2:0]]}};
	// A released bus shows the inverse of the last value the device drove, never a kept one.
	wire [15:0] bus = dataOeN ? ~lastQ : dataOut;
	assign dataIn = devOn ? devQ : ~lastQ;
	always @(negedge clk)
	begin
		if (devOn) lastQ <= devQ;
		if (arrSel && !readWriteN)
		begin
			if (!upper_byte_select_n) mem[addr][15:8] <= bus[15:8];
			if (!lower_byte_select_n) mem[addr][7:0] <= bus[7:0];
		end
		// Only one port is modelled, so no contention arises and the last write holds the flag.
		if (flgSel && !readWriteN) flag[addr[2:0]] <= bus[0];
	end
endmodule // dpwr_ram_model
`default_nettype wire

/* test/test_dpwr_host.sv */
// Self-checking bench for the RAM host.
`timescale 1ns/1ps
`default_nettype none
module test_dpwr_host;
	logic clk = 1'h0, resetn = 1'h0, reqValid = 1'h0, reqOutEnable = 1'h0;
	logic [1:0] reqCmd = 2'h0, reqByteEn = 2'h0, b;
	logic [12:0] reqAddr = 13'h0, addr;
	logic [15:0] reqData = 16'h0, rspData, dataIn, dataOut, d0, d1;
	logic reqReady, rspValid, chipSelectN, upper_byte_select_n, lower_byte_select_n;
	logic flag_select_n, readWriteN, outputEnableN, dataOeN;
	logic [15:0] expQ[$];
	int fail_count = 0, check_count = 0, cyc = 0, seed = 27;
	always #50 clk = ~clk;
	dpwr_host dpwr_host_inst (
		.clk(clk),
		.resetn(resetn),
		.reqValid(reqValid),
		.reqCmd(reqCmd),
		.reqAddr(reqAddr),
		.reqData(reqData),
		.reqByteEn(reqByteEn),
		.reqOutEnable(reqOutEnable),
		.reqReady(reqReady),
		.rspValid(rspValid),
		.rspData(rspData),
		.addr(addr),
		.chipSelectN(chipSelectN),
		.upper_byte_select_n(upper_byte_select_n),
		.lower_byte_select_n(lower_byte_select_n),
		.flag_select_n(flag_select_n),
		.readWriteN(readWriteN),
		.outputEnableN(outputEnableN),
		.dataIn(dataIn),
		.dataOut(dataOut),
		.dataOeN(dataOeN)
	);
	dpwr_ram_model dpwr_ram_model_inst (
		.clk(clk),
		.addr(addr),
		.chipSelectN(chipSelectN),
		.upper_byte_select_n(upper_byte_select_n),
		.lower_byte_select_n(lower_byte_select_n),
		.flag_select_n(flag_select_n),
		.readWriteN(readWriteN),
		.outputEnableN(outputEnableN),
		.dataOut(dataOut),
		.dataOeN(dataOeN),
		.dataIn(dataIn)
	);
	task check(input string n, input [15:0] seen, input [15:0] want);
		check_count++;
		if (seen !== want)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", n, want, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task op(input [1:0] c, input [12:0] a, input [15:0] d, input [1:0] be, input [15:0] e);
		reqCmd <= c;
		reqAddr <= a;
		reqData <= d;
		reqByteEn <= be;
		reqValid <= 1'h1;
		@(posedge clk);
		while (reqReady !== 1'h1)
			@(posedge clk);
		if (c[0]) expQ.push_back(e);
		reqValid <= 1'h0;
		@(posedge clk);
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (rspValid === 1'h1) check("rspData", rspData, expQ.pop_front());
		if (cyc == 3000)
		begin
			fail_count++;
			wrap_up;
		end
	end
	initial
	begin
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		repeat (2) @(posedge clk);
		for (int i = 0; i < 12; i++)
		begin
			d0 = $random(seed);
			d1 = $random(seed);
			b = 2'(i % 3 + 1);
			reqOutEnable <= i[0];
			op(2'h0, d0[12:0], d0, 2'h3, 16'h0);
			op(2'h0, d0[12:0], d1, b, 16'h0);
			op(2'h1, d0[12:0], 16'h0, 2'h3,
				{b[1] ? d1[15:8] : d0[15:8], b[0] ? d1[7:0] : d0[7:0]});
		end
		for (int i = 0; i < 4; i++)
		begin
			op(2'h2, 13'(i), {15'h0, i[1]}, 2'h3, 16'h0);
			op(2'h3, 13'(i), 16'h0, 2'h3, {16{i[1]}});
		end
		repeat (9) @(posedge clk);
		check("pending", 16'(expQ.size()), 16'h0);
		wrap_up;
	end
endmodule // test_dpwr_host
`default_nettype wire
